/* aipm_regs.svh */
`ifndef AIPM_REGS_SVH
`define AIPM_REGS_SVH

// ==========================================================
// Register map
`define AIPM_ADDR_W 4
`define AIPM_DATA_W 16
`define AIPM_ADDR_CFG 4'h0
`define AIPM_ADDR_STAT 4'h4

// ==========================================================
// Configuration word fields
`define AIPM_CFG_RST 16'h0200
`define AIPM_LD_HI 15
`define AIPM_LD_LO 14
`define AIPM_LD_ON 2'h3
`define AIPM_PM_HI 10
`define AIPM_PM_LO 9
`define AIPM_CFG_BITS 16
`define AIPM_CFG_LAST 4'hf

// ==========================================================
// Status word fields
`define AIPM_ST_EARLY 0
`define AIPM_ST_WAKING 1
`define AIPM_ST_PEND 2
`define AIPM_ST_POL_LO 3
`define AIPM_ST_POL_HI 4
`define AIPM_ST_STATE_LO 5
`define AIPM_ST_STATE_HI 6

// ==========================================================
// Power levels shown on power_level
`define AIPM_PWR_FULL 2'h0
`define AIPM_PWR_SLEEP 2'h1
`define AIPM_PWR_DOWN 2'h2

// ==========================================================
// Timing
`define AIPM_CLK_NS 50
`define AIPM_PD_WAKE_US 150
`define AIPM_PD_WAKE_CYC ((`AIPM_PD_WAKE_US * 1000 + `AIPM_CLK_NS - 1) / `AIPM_CLK_NS)

`endif

/* aipm_pkg.sv */
package aipm_pkg;

  // ==========================================================
  // Operating states and idle policies
  typedef enum logic [1:0] {AIPM_ACQ, AIPM_CONV, AIPM_IDLE} aipm_state_t;
  typedef enum logic [1:0] {AIPM_CONT, AIPM_PDOWN, AIPM_SLEEP} aipm_pol_t;

  // ==========================================================
  // Core domain state
  typedef struct packed {
    aipm_state_t st;
    aipm_pol_t pol;
    logic [15:0] cfg;
    logic pend;
    logic waking;
    logic [11:0] wcnt;
    logic [7:0] ccnt;
    logic cnv_s1;
    logic cnv_s2;
    logic cnv_s3;
    logic tg_s1;
    logic tg_s2;
    logic tg_s3;
    logic early;
    logic busy;
    logic [1:0] pwr;
    logic [15:0] rdata;
  } aipm_core_t;

  // ==========================================================
  // Serial link domain state
  typedef struct packed {
    logic [15:0] sh;
    logic [3:0] cnt;
    logic [15:0] word;
    logic tog;
  } aipm_link_t;

endpackage

/* aipm_lnk_if.sv */
`timescale 1ns/1ps
// Word handed from the serial clock domain to the core domain
interface aipm_lnk_if;
  logic [15:0] word;
  logic tog;
  modport link
  (
    output word,
    output tog
  );
  modport core
  (
    input word,
    input tog
  );
endinterface

/* aipm_link.sv */
`timescale 1ns/1ps
`include "aipm_regs.svh"
module aipm_link
  import aipm_pkg::*;
(
  input wire logic sclk,
  input wire logic sys_rst,
  input wire logic cnv,
  input wire logic sdi,
  aipm_lnk_if.link lnk
);

  aipm_link_t q;
  aipm_link_t n;

  // ==========================================================
  // Shift in a configuration word, MSB first
  // Word stays put for 16 more edges, so the core can sample it after the toggle syncs
  always_comb
  begin
    n = q;
    if (cnv)
    begin
      n.cnt = '0; // Converting high frames off a partial word
    end
    else
    begin
      n.sh = {q.sh[14:0], sdi};
      n.cnt = q.cnt + 4'h1;
      if (q.cnt == `AIPM_CFG_LAST)
      begin
        n.word = {q.sh[14:0], sdi};
        n.tog = ~q.tog;
      end
    end
  end

  // Link domain registers, clocked only while the host runs the serial clock
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
      q <= '0;
    else
      q <= n;
  end

  assign lnk.word = q.word;
  assign lnk.tog = q.tog;

endmodule

/* aipm_top.sv */
`timescale 1ns/1ps
`include "aipm_regs.svh"
// What this block does
// - Cycle acquisition, conversion, idle in every mode
// - Idle behaviour chosen only by policy bits
// - Continuous: stay powered, re-acquire at once
// - Auto sleep: sleep in idle, wake first
// - Power-down in idle, 150 us wake-up
// - Policy 00 down, 01 continuous, 1x sleep
// - New policy applies at the next conversion end after it loads
// - Word loads only with load pair 11
module aipm_top
  import aipm_pkg::*;
#(
  parameter logic [7:0] CONV_CYCLES = 8'h10,
  parameter logic [11:0] SLEEP_WAKE_CYC = 12'h014
)
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic cnv,
  input wire logic sdi,
  input wire logic [`AIPM_ADDR_W-1:0] reg_addr,
  input wire logic [`AIPM_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`AIPM_DATA_W-1:0] reg_rdata,
  output logic conv_busy,
  output logic [1:0] power_level
);

  localparam logic [11:0] PD_WAKE_CYC = 12'(`AIPM_PD_WAKE_CYC);

  aipm_core_t q;
  aipm_core_t n;
  aipm_lnk_if lnk ();

  // ==========================================================
  // Serial link front end on its own clock
  aipm_link u_link
  (
    .sclk(sclk),
    .sys_rst(sys_rst),
    .cnv(cnv),
    .sdi(sdi),
    .lnk(lnk.link)
  );

  // ==========================================================
  // Policy decode: upper bit overrides lower
  function automatic aipm_pol_t pol_decode(input logic [1:0] bits);
    aipm_pol_t p;
    if (bits[1])
      p = AIPM_SLEEP;
    else if (bits[0])
      p = AIPM_CONT;
    else
      p = AIPM_PDOWN;
    return p;
  endfunction

  // Edges seen after the two-flop synchronisers
  logic cnv_rise;
  logic cnv_fall;
  logic word_new;
  logic conv_done;
  assign cnv_rise = q.cnv_s2 & ~q.cnv_s3;
  assign cnv_fall = ~q.cnv_s2 & q.cnv_s3;
  assign word_new = q.tg_s2 ^ q.tg_s3;
  assign conv_done = (q.st == AIPM_CONV) && (q.ccnt == CONV_CYCLES - 8'h01);

  // Accepted configuration loads from either side
  logic ser_load;
  logic bus_load;
  assign ser_load = word_new && lnk.word[`AIPM_LD_HI:`AIPM_LD_LO] == `AIPM_LD_ON;
  assign bus_load = reg_wr && reg_addr == `AIPM_ADDR_CFG
                    && reg_wdata[`AIPM_LD_HI:`AIPM_LD_LO] == `AIPM_LD_ON;

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    n = q;
    n.cnv_s1 = cnv;
    n.cnv_s2 = q.cnv_s1;
    n.cnv_s3 = q.cnv_s2;
    n.tg_s1 = lnk.tog;
    n.tg_s2 = q.tg_s1;
    n.tg_s3 = q.tg_s2;

    // Configuration loads, serial first, bus wins a tie
    if (ser_load)
    begin
      n.cfg = lnk.word;
      n.pend = 1'b1;
    end
    if (bus_load)
    begin
      n.cfg = reg_wdata;
      n.pend = 1'b1;
    end

    // Write one clears the early flag; a new event below still wins
    if (reg_wr && reg_addr == `AIPM_ADDR_STAT && reg_wdata[`AIPM_ST_EARLY])
      n.early = 1'b0;

    // Operating state machine
    unique case (q.st)
      AIPM_ACQ:
      begin
        n.pwr = `AIPM_PWR_FULL;
        if (cnv_rise)
        begin
          n.st = AIPM_CONV;
          n.ccnt = '0;
          n.busy = 1'b1;
        end
      end
      AIPM_CONV:
      begin
        n.ccnt = q.ccnt + 8'h01;
        if (conv_done)
        begin
          n.st = AIPM_IDLE;
          n.busy = 1'b0;
          // Policy written mid-conversion only takes hold here
          if (q.pend)
          begin
            n.pol = pol_decode(q.cfg[`AIPM_PM_HI:`AIPM_PM_LO]);
            // A word landing in this very cycle stays pending for the next end
            n.pend = ser_load || bus_load;
          end
          // Idle power level follows the policy alone
          unique case (n.pol)
            AIPM_CONT: n.pwr = `AIPM_PWR_FULL;
            AIPM_SLEEP: n.pwr = `AIPM_PWR_SLEEP;
            AIPM_PDOWN: n.pwr = `AIPM_PWR_DOWN;
            default: n.pwr = `AIPM_PWR_FULL;
          endcase
        end
      end
      AIPM_IDLE:
      begin
        if (q.waking)
        begin
          if (q.wcnt == 12'h000)
          begin
            n.st = AIPM_ACQ;
            n.waking = 1'b0;
          end
          else
          begin
            n.wcnt = q.wcnt - 12'h001;
          end
        end
        else if (cnv_fall)
        begin
          if (q.pol == AIPM_CONT)
          begin
            n.st = AIPM_ACQ;
          end
          else
          begin
            // Power up now; acquisition opens once the wake count expires
            n.waking = 1'b1;
            n.pwr = `AIPM_PWR_FULL;
            n.wcnt = (q.pol == AIPM_SLEEP) ? SLEEP_WAKE_CYC - 12'h001
                                           : PD_WAKE_CYC - 12'h001;
          end
        end
        // Host started converting before the wake-up ended: not honoured
        if (cnv_rise)
          n.early = 1'b1;
      end
      default:
      begin
        n.st = AIPM_IDLE;
      end
    endcase

    // Read data stand one cycle after the strobe only
    n.rdata = '0;
    if (reg_rd)
    begin
      if (reg_addr == `AIPM_ADDR_CFG)
        n.rdata = q.cfg;
      else if (reg_addr == `AIPM_ADDR_STAT)
      begin
        n.rdata[`AIPM_ST_EARLY] = q.early;
        n.rdata[`AIPM_ST_WAKING] = q.waking;
        n.rdata[`AIPM_ST_PEND] = q.pend;
        n.rdata[`AIPM_ST_POL_HI:`AIPM_ST_POL_LO] = q.pol;
        n.rdata[`AIPM_ST_STATE_HI:`AIPM_ST_STATE_LO] = q.st;
      end
    end
  end

  // ==========================================================
  // State register; clock enable low freezes everything
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.cfg <= `AIPM_CFG_RST;
    end
    else if (clk_en)
    begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign conv_busy = q.busy;
  assign power_level = q.pwr;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // State sequence: three states, always in the same order
  chk_three_states: assert property (q.st inside {AIPM_ACQ, AIPM_CONV, AIPM_IDLE})
    else $error("state outside acquisition, conversion, idle");

  chk_acq_to_conv: assert property (
    (q.st == AIPM_ACQ && cnv_rise && clk_en) |=> q.st == AIPM_CONV && q.busy)
    else $error("convert strobe did not start a conversion");

  chk_conv_stays: assert property (
    (q.st == AIPM_CONV && !conv_done) |=> q.st == AIPM_CONV && q.busy)
    else $error("conversion ended early");

  chk_conv_to_idle: assert property (
    (conv_done && clk_en) |=> q.st == AIPM_IDLE && !q.busy)
    else $error("conversion end did not reach idle");

  chk_idle_holds: assert property (
    (q.st == AIPM_IDLE && !q.waking && !cnv_fall) |=> q.st == AIPM_IDLE)
    else $error("idle left without a host start");

  chk_early_flag: assert property (
    (q.st == AIPM_IDLE && cnv_rise && clk_en) |=> q.early && q.st != AIPM_CONV)
    else $error("strobe in idle was not refused");

  // Idle power follows the policy, wake-up precedes acquisition
  chk_cont_powered: assert property (
    (q.st == AIPM_IDLE && q.pol == AIPM_CONT) |-> q.pwr == `AIPM_PWR_FULL)
    else $error("continuous policy left idle unpowered");

  chk_cont_fast: assert property (
    (q.st == AIPM_IDLE && !q.waking && q.pol == AIPM_CONT && cnv_fall && clk_en)
    |=> q.st == AIPM_ACQ)
    else $error("continuous policy did not re-acquire at once");

  chk_sleep_level: assert property (
    (q.st == AIPM_IDLE && !q.waking && q.pol == AIPM_SLEEP) |-> q.pwr == `AIPM_PWR_SLEEP)
    else $error("auto sleep idle not sleeping");

  chk_sleep_wake: assert property (
    (q.st == AIPM_IDLE && !q.waking && q.pol == AIPM_SLEEP && cnv_fall && clk_en)
    |=> q.waking && q.wcnt == SLEEP_WAKE_CYC - 12'h001)
    else $error("sleep wake count wrong");

  chk_down_level: assert property (
    (q.st == AIPM_IDLE && !q.waking && q.pol == AIPM_PDOWN) |-> q.pwr == `AIPM_PWR_DOWN)
    else $error("auto power-down idle not powered down");

  chk_down_wake: assert property (
    (q.st == AIPM_IDLE && !q.waking && q.pol == AIPM_PDOWN && cnv_fall && clk_en)
    |=> q.waking && q.wcnt == PD_WAKE_CYC - 12'h001)
    else $error("power-down wake count wrong");

  chk_wake_exit: assert property (
    (q.waking && q.wcnt == 12'h000 && clk_en)
    |=> q.st == AIPM_ACQ && q.pwr == `AIPM_PWR_FULL)
    else $error("wake-up did not end in acquisition");

  // Policy loads and the moment they take hold
  chk_pol_apply: assert property (
    (conv_done && q.pend && clk_en)
    |=> q.pol == ($past(q.cfg[`AIPM_PM_HI]) ? AIPM_SLEEP
                 : $past(q.cfg[`AIPM_PM_LO]) ? AIPM_CONT : AIPM_PDOWN))
    else $error("policy decode wrong at conversion end");

  chk_pol_hold: assert property (!(conv_done && clk_en) |=> $stable(q.pol))
    else $error("policy changed outside conversion end");

  chk_load_pend: assert property (
    ((ser_load || bus_load) && clk_en) |=> q.pend)
    else $error("accepted word not left pending");

  chk_load_guard: assert property (
    (clk_en && !ser_load && !bus_load) |=> $stable(q.cfg))
    else $error("configuration loaded without load pair");

  // Main scenarios
  cov_down_wake: cover property (q.pol == AIPM_PDOWN && q.waking ##1 q.st == AIPM_ACQ);
  cov_sleep_wake: cover property (q.pol == AIPM_SLEEP && q.waking ##1 q.st == AIPM_ACQ);
  cov_pol_change: cover property (conv_done && q.pend && clk_en);
  cov_early: cover property ($rose(q.early));
  cov_frozen_write: cover property (!clk_en && reg_wr);

endmodule

/* aipm_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Host side: serial config loader and convert strobe
module aipm_host_model
(
  core_clk,
  sclk,
  sdi,
  cnv
);
  input wire logic core_clk;
  output logic sclk;
  output logic sdi;
  output logic cnv;

  // Link clock stands still outside frames
  initial
  begin
    sclk = 1'b0;
    sdi = 1'b0;
    cnv = 1'b0;
  end

  // ==========================================================
  // One word, MSB first, 32 ns link clock only inside the frame
  task automatic send_word(input logic [15:0] w);
    #7;
    for (int i = 15; i >= 0; i--)
    begin
      sdi = w[i];
      #16 sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    // Released line flips so a stale bit never reads as valid
    sdi = ~w[0];
  endtask

  // Strobe level changes right after a core edge
  task automatic set_cnv(input logic v);
    @(posedge core_clk);
    cnv <= v;
  endtask

  // Hold convert low through wake-up plus acquisition
  task automatic sample(input int n);
    set_cnv(1'b0);
    repeat (n) @(posedge core_clk);
  endtask
endmodule

/* test_adc_idle_power_manager.sv */
`timescale 1ns/1ps
`include "aipm_regs.svh"
module test_adc_idle_power_manager
  import aipm_pkg::*;
;
  typedef struct {
    logic [15:0] cfg;
    logic [1:0] pwr;
    logic [1:0] pol;
    int wake;
  } aipm_row_t;
  localparam int CONV_N = 16;
  localparam int SLEEP_W = 20;
  localparam int PD_W = `AIPM_PD_WAKE_CYC;
  logic core_clk;
  logic sys_rst;
  logic clk_en;
  logic sclk;
  logic cnv;
  logic sdi;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic conv_busy;
  logic [1:0] power_level;
  logic [15:0] rdat;
  int bad_count;
  int check_count;
  // Policy codes with the idle level, status policy and wake span each gives
  aipm_row_t rows [5] = '{
    '{16'hc200, `AIPM_PWR_FULL, AIPM_CONT, 4},
    '{16'hc000, `AIPM_PWR_DOWN, AIPM_PDOWN, PD_W},
    '{16'hc400, `AIPM_PWR_SLEEP, AIPM_SLEEP, SLEEP_W},
    '{16'hc600, `AIPM_PWR_SLEEP, AIPM_SLEEP, SLEEP_W},
    '{16'hc2ff, `AIPM_PWR_FULL, AIPM_CONT, 4}};

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  aipm_host_model u_host
  (
    .core_clk(core_clk),
    .sclk(sclk),
    .sdi(sdi),
    .cnv(cnv)
  );

  // Default timing, so the bench sees what a host would
  aipm_top u_dut
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .sclk(sclk),
    .cnv(cnv),
    .sdi(sdi),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .conv_busy(conv_busy),
    .power_level(power_level)
  );

  // ==========================================================
  // Checking and bus tasks
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string m);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic chk_num(input int g, input int e, input string m);
    check_count++;
    if (g != e)
    begin
      bad_count++;
      $display("BAD %0t %s got %0d exp %0d", $time, m, g, e);
    end
  endtask

  function automatic logic [15:0] stat(input logic [1:0] s, input logic [1:0] p,
                                       input logic pe, input logic w, input logic e);
    return {9'h000, s, p, pe, w, e};
  endfunction

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // One conversion, then the idle level it leaves behind
  task automatic convert(input logic [1:0] pw);
    int n;
    int g;
    n = 0;
    g = 0;
    u_host.set_cnv(1'b1);
    while (conv_busy !== 1'b1 && g < 20)
    begin
      @(posedge core_clk);
      #1;
      g++;
    end
    while (conv_busy === 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk_num(n, CONV_N, "busy span");
    @(posedge core_clk);
    #1;
    chk_word(16'(power_level), 16'(pw), "idle power");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // Watchdog: all tests need well under 2 ms
  initial
  begin
    #2000000;
    bad_count++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    bad_count = 0;
    check_count = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk_word(16'(power_level), 16'(`AIPM_PWR_FULL), "reset power");
    rd(`AIPM_ADDR_CFG, rdat);
    chk_word(rdat, `AIPM_CFG_RST, "reset cfg");
    rd(`AIPM_ADDR_STAT, rdat);
    chk_word(rdat, 16'h0000, "reset status");
    $display("reset test done");
    // Every policy code: idle level, wake span, return to acquisition
    for (int i = 0; i < 5; i++)
    begin
      u_host.send_word(rows[i].cfg);
      repeat (8) @(posedge core_clk);
      convert(rows[i].pwr);
      rd(`AIPM_ADDR_STAT, rdat);
      chk_word(rdat, stat(2'h2, rows[i].pol, 1'b0, 1'b0, 1'b0), "idle");
      u_host.sample(rows[i].wake - 4);
      rd(`AIPM_ADDR_STAT, rdat);
      chk_word(rdat, stat(2'h2, rows[i].pol, 1'b0, rows[i].wake > 4, 1'b0), "wake");
      repeat (12) @(posedge core_clk);
      rd(`AIPM_ADDR_STAT, rdat);
      chk_word(rdat, stat(2'h0, rows[i].pol, 1'b0, 1'b0, 1'b0), "acq");
      chk_word(16'(power_level), 16'(`AIPM_PWR_FULL), "awake");
      $display("policy row %0d done", i);
    end
    // Words without load pair 11 leave the configuration alone
    u_host.send_word(16'h4000);
    wr(`AIPM_ADDR_CFG, 16'h8000);
    repeat (8) @(posedge core_clk);
    rd(`AIPM_ADDR_CFG, rdat);
    chk_word(rdat, 16'hc2ff, "refused load");
    $display("load pair test done");
    // Policy change in idle waits; early strobe during wake is ignored
    wr(`AIPM_ADDR_CFG, 16'hc000);
    convert(`AIPM_PWR_DOWN);
    wr(`AIPM_ADDR_CFG, 16'hc200);
    rd(`AIPM_ADDR_STAT, rdat);
    chk_word(rdat, stat(2'h2, AIPM_PDOWN, 1'b1, 1'b0, 1'b0), "pending");
    chk_word(16'(power_level), 16'(`AIPM_PWR_DOWN), "still down");
    u_host.sample(100);
    u_host.set_cnv(1'b1);
    repeat (8) @(posedge core_clk);
    #1;
    chk_word(16'(conv_busy), 16'h0000, "early strobe");
    rd(`AIPM_ADDR_STAT, rdat);
    chk_word(rdat, stat(2'h2, AIPM_PDOWN, 1'b1, 1'b1, 1'b1), "early");
    repeat (PD_W) @(posedge core_clk);
    rd(`AIPM_ADDR_STAT, rdat);
    chk_word(rdat, stat(2'h0, AIPM_PDOWN, 1'b1, 1'b0, 1'b1), "woken");
    u_host.sample(8);
    convert(`AIPM_PWR_FULL);
    wr(`AIPM_ADDR_STAT, 16'h0001);
    rd(`AIPM_ADDR_STAT, rdat);
    chk_word(rdat, stat(2'h2, AIPM_CONT, 1'b0, 1'b0, 1'b0), "cleared");
    rd(4'h8, rdat);
    chk_word(rdat, 16'h0000, "unmapped");
    $display("wake and pending test done");
    // Clock enable low: the write is lost and the cnv fall waits for the thaw
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(`AIPM_ADDR_CFG, 16'hc400);
    u_host.sample(8);
    clk_en <= 1'b1;
    rd(`AIPM_ADDR_CFG, rdat);
    chk_word(rdat, 16'hc200, "frozen write");
    rd(`AIPM_ADDR_STAT, rdat);
    chk_word(rdat, stat(2'h0, AIPM_CONT, 1'b0, 1'b0, 1'b0), "thawed fall");
    $display("clock enable test done");
    // Reset in mid-run drops a pending word and restores the power-on state
    wr(`AIPM_ADDR_CFG, 16'hc400);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(`AIPM_ADDR_CFG, rdat);
    chk_word(rdat, `AIPM_CFG_RST, "cfg after reset");
    rd(`AIPM_ADDR_STAT, rdat);
    chk_word(rdat, 16'h0000, "status after reset");
    chk_word(16'(power_level), 16'(`AIPM_PWR_FULL), "power after reset");
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
